// >>> core/obsl_consts.vh
`ifndef OBSL_CONSTS_VH
`define OBSL_CONSTS_VH
// Register byte offsets
`define OBSL_REG_CTRL 8'h00
`define OBSL_REG_STRAP 8'h04
`define OBSL_REG_IRQ_STAT 8'h08
`define OBSL_REG_IRQ_MASK 8'h0c
`define OBSL_REG_SYNC_CFG 8'h10
`define OBSL_REG_PROG_CFG 8'h14
`define OBSL_REG_PIN_IN 8'h18
`define OBSL_REG_TEST_OUT 8'h1c
// Control fields
`define OBSL_CTRL_ACTIVE 0
`define OBSL_CTRL_FAULT 1
`define OBSL_CTRL_MEDIA_EN 2
`define OBSL_CTRL_SYNC_GO 3
// Strap fields
`define OBSL_STRAP_AUTO 0
`define OBSL_STRAP_WPROT 1
`define OBSL_STRAP_TEST 2
`define OBSL_STRAP_READY 3
// Event bits
`define OBSL_EV_SYNC_IN 0
`define OBSL_EV_PROG1 1
`define OBSL_EV_PROG2 2
`define OBSL_EV_WR_BLOCK 3
`define OBSL_EV_TEST 4
`define OBSL_EV_W 5
// Reset values
`define OBSL_SYNC_WIDTH_RST 16'h0028
`define OBSL_SYNC_PERIOD_RST 16'h0000
`endif

// >>> core/obsl_sync_pulse.v
`timescale 1ns/100ps
// Active-low sync pulse generator, one-shot or periodic
module obsl_sync_pulse #(
    parameter CW = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire start,
    input wire [CW-1:0] width,
    input wire [CW-1:0] period,
    output reg drive
);
    reg [CW-1:0] wcnt;
    reg [CW-1:0] pcnt;
    reg running;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wcnt <= {CW{1'b0}};
            pcnt <= {CW{1'b0}};
            running <= 1'b0;
            drive <= 1'b0;
        end else begin
            if (start && !running) begin
                running <= 1'b1;
                drive <= (width != {CW{1'b0}});
                wcnt <= width;
                pcnt <= period;
            end else if (running) begin
                if (wcnt > {{(CW-1){1'b0}}, 1'b1}) begin
                    wcnt <= wcnt - {{(CW-1){1'b0}}, 1'b1};
                end else begin
                    wcnt <= {CW{1'b0}};
                    drive <= 1'b0;
                end
                // Zero period means one-shot
                if (period == {CW{1'b0}}) begin
                    if (wcnt <= {{(CW-1){1'b0}}, 1'b1}) begin
                        running <= 1'b0;
                    end
                end else if (pcnt > {{(CW-1){1'b0}}, 1'b1}) begin
                    pcnt <= pcnt - {{(CW-1){1'b0}}, 1'b1};
                end else begin
                    pcnt <= period;
                    wcnt <= width;
                    drive <= (width != {CW{1'b0}});
                    // Periodic runs on until the period is cleared
                    running <= 1'b1;
                end
            end
        end
    end
endmodule // obsl_sync_pulse

// >>> core/obsl_option_bay.v
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "obsl_consts.vh"
module obsl_option_bay (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg irq,
    input wire test_mode_n,
    input wire auto_start_n,
    input wire write_inhibit_n,
    input wire sync_in,
    output reg sync_out,
    output reg sync_oe,
    output reg activity_oe,
    output reg fault_oe,
    input wire prog1_in,
    output reg prog1_oe,
    input wire prog2_in,
    output reg prog2_oe,
    input wire user_write_req,
    output reg user_write_grant,
    output reg media_ready
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    reg wr_pend;
    reg rd_pend;
    reg [7:0] addr_q;
    wire take = hsel && hready && htrans[1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
            if (take) begin
                addr_q <= haddr;
            end
        end
    end

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    // Straps are caught one edge after reset release, never by the
    // async reset itself; auto_strap and wprot_strap latched until next reset.
    reg strap_done;
    reg auto_strap;
    reg wprot_strap;
    reg test_strap;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done <= 1'b0;
            auto_strap <= 1'b0;
            wprot_strap <= 1'b1;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            auto_strap <= !auto_start_n;
            wprot_strap <= !write_inhibit_n;
        end
    end
    // Test mode follows the pin live so a fixture can release it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_strap <= 1'b0;
        end else begin
            test_strap <= !test_mode_n;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    reg [3:0] ctrl;
    reg [`OBSL_EV_W-1:0] irq_stat;
    reg [`OBSL_EV_W-1:0] irq_mask;
    reg [15:0] sync_width;
    reg [15:0] sync_period;
    reg [3:0] prog_cfg;
    reg [6:0] test_out;
    reg sync_in_q;
    reg prog1_q;
    reg prog2_q;
    wire sync_drive;

    // Data-phase strobe for one register offset
    function addr_hit(input pend, input [7:0] at, input [7:0] off);
        addr_hit = pend && (at == off);
    endfunction

    // Read clears only the bits it returned; a later event survives
    function [`OBSL_EV_W-1:0] stat_next(
        input [`OBSL_EV_W-1:0] cur,
        input clr,
        input [`OBSL_EV_W-1:0] shown,
        input [`OBSL_EV_W-1:0] evs
    );
        stat_next = (clr ? (cur & ~shown) : cur) | evs;
    endfunction

    wire wr_ctrl = addr_hit(wr_pend, addr_q, `OBSL_REG_CTRL);
    wire rd_stat = addr_hit(rd_pend, addr_q, `OBSL_REG_IRQ_STAT);
    wire wr_block = user_write_req && wprot_strap && strap_done;
    wire [`OBSL_EV_W-1:0] shown_stat = hrdata[`OBSL_EV_W-1:0];
    wire [`OBSL_EV_W-1:0] ev;
    // Pin falling edges, test-mode release and write-block level; own drive masked except prog pins driven in test mode
    assign ev[`OBSL_EV_TEST] = test_strap && test_mode_n;
    assign ev[`OBSL_EV_WR_BLOCK] = wr_block;
    assign ev[`OBSL_EV_PROG2] = prog2_q && !prog2_in && !prog_cfg[1];
    assign ev[`OBSL_EV_PROG1] = prog1_q && !prog1_in && !prog_cfg[0];
    assign ev[`OBSL_EV_SYNC_IN] = sync_in_q && !sync_in && !sync_oe;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= 4'h0;
            irq_mask <= {`OBSL_EV_W{1'b0}};
            irq_stat <= {`OBSL_EV_W{1'b0}};
            sync_width <= `OBSL_SYNC_WIDTH_RST;
            sync_period <= `OBSL_SYNC_PERIOD_RST;
            prog_cfg <= 4'h0;
            test_out <= 7'h00;
            sync_in_q <= 1'b1;
            prog1_q <= 1'b1;
            prog2_q <= 1'b1;
        end else begin
            sync_in_q <= sync_in;
            prog1_q <= prog1_in;
            prog2_q <= prog2_in;
            // Read clears, but a same-cycle event still sets
            irq_stat <= stat_next(irq_stat, rd_stat, shown_stat, ev);
            if (wr_ctrl) begin
                ctrl <= hwdata[3:0];
            end else begin
                ctrl[`OBSL_CTRL_SYNC_GO] <= 1'b0;
            end
            if (addr_hit(wr_pend, addr_q, `OBSL_REG_IRQ_MASK)) begin
                irq_mask <= hwdata[`OBSL_EV_W-1:0];
            end
            if (addr_hit(wr_pend, addr_q, `OBSL_REG_SYNC_CFG)) begin
                sync_width <= hwdata[15:0];
                sync_period <= hwdata[31:16];
            end
            if (addr_hit(wr_pend, addr_q, `OBSL_REG_PROG_CFG)) begin
                prog_cfg <= hwdata[3:0];
            end
            if (addr_hit(wr_pend, addr_q, `OBSL_REG_TEST_OUT)) begin
                test_out <= hwdata[6:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Sync pulse generator
    // ------------------------------------------------------------
    obsl_sync_pulse #(
        .CW(16)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(ctrl[`OBSL_CTRL_SYNC_GO]),
        .width(sync_width),
        .period(sync_period),
        .drive(sync_drive)
    );

    // ------------------------------------------------------------
    // Pin drive and bus outputs
    // ------------------------------------------------------------
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h0000_0000;
        case (haddr)
        `OBSL_REG_CTRL: next_rdata = {28'h0, ctrl};
        `OBSL_REG_STRAP: next_rdata = {28'h0, media_ready, test_strap,
            wprot_strap, auto_strap};
        `OBSL_REG_IRQ_STAT: next_rdata = {27'h0, irq_stat};
        `OBSL_REG_IRQ_MASK: next_rdata = {27'h0, irq_mask};
        `OBSL_REG_SYNC_CFG: next_rdata = {sync_period, sync_width};
        `OBSL_REG_PROG_CFG: next_rdata = {28'h0, prog_cfg};
        `OBSL_REG_PIN_IN: next_rdata = {29'h0, !prog2_in, !prog1_in,
            !sync_in};
        `OBSL_REG_TEST_OUT: next_rdata = {25'h0, test_out};
        default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq <= 1'b0;
            sync_out <= 1'b1;
            sync_oe <= 1'b0;
            activity_oe <= 1'b0;
            fault_oe <= 1'b0;
            prog1_oe <= 1'b0;
            prog2_oe <= 1'b0;
            user_write_grant <= 1'b0;
            media_ready <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take && !hwrite) begin
                hrdata <= next_rdata;
            end
            irq <= |(stat_next(irq_stat, rd_stat, shown_stat, ev)
                & irq_mask);
            media_ready <= strap_done && (auto_strap
                || ctrl[`OBSL_CTRL_MEDIA_EN]);
            user_write_grant <= user_write_req && strap_done
                && !wprot_strap;
            sync_out <= 1'b0;
            if (test_strap) begin
                // Tester owns the drivable pins
                sync_oe <= test_out[0];
                activity_oe <= test_out[1];
                fault_oe <= test_out[2];
                prog1_oe <= test_out[3];
                prog2_oe <= test_out[4];
            end else begin
                sync_oe <= sync_drive;
                activity_oe <= ctrl[`OBSL_CTRL_ACTIVE];
                fault_oe <= ctrl[`OBSL_CTRL_FAULT];
                prog1_oe <= prog_cfg[0] && prog_cfg[2];
                prog2_oe <= prog_cfg[1] && prog_cfg[3];
            end
        end
    end
endmodule // obsl_option_bay

// >>> tb/obsl_properties.sv
`timescale 1ns/100ps
`include "obsl_consts.vh"
module obsl_properties (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire test_mode_n,
    input wire auto_start_n,
    input wire write_inhibit_n,
    input wire sync_out,
    input wire sync_oe,
    input wire activity_oe,
    input wire fault_oe,
    input wire user_write_req,
    input wire user_write_grant,
    input wire media_ready
);
    // ----
    // Strap copy taken at the first edge after reset
    // ----
    reg seen;
    reg wp_l;
    reg au_l;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen <= 1'b0;
        end else if (!seen) begin
            seen <= 1'b1;
            wp_l <= ~write_inhibit_n;
            au_l <= ~auto_start_n;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_ctrl_wr;
        hsel && hready && htrans[1] && hwrite && haddr == `OBSL_REG_CTRL
        ##1 test_mode_n;
    endsequence
    property p_act;
        s_ctrl_wr ##0 hwdata[`OBSL_CTRL_ACTIVE] |-> ##[1:2] activity_oe;
    endproperty
    property p_flt;
        s_ctrl_wr ##0 hwdata[`OBSL_CTRL_FAULT] |-> ##[1:2] fault_oe;
    endproperty
    property p_go;
        s_ctrl_wr ##0 hwdata[`OBSL_CTRL_SYNC_GO] |-> ##[1:4] sync_oe;
    endproperty
    property p_od;
        seen |-> !sync_out;
    endproperty
    property p_okay;
        hreadyout && !hresp;
    endproperty
    property p_wp;
        seen && $past(seen) && wp_l |-> !user_write_grant;
    endproperty
    property p_wpass;
        seen && $past(seen) && !wp_l
        |-> user_write_grant == $past(user_write_req);
    endproperty
    property p_auto;
        seen && au_l |-> ##[0:20] media_ready;
    endproperty
    a_act: assert property (p_act) else $error("activity off");
    a_flt: assert property (p_flt) else $error("fault off");
    a_go: assert property (p_go) else $error("no sync pulse");
    a_od: assert property (p_od) else $error("sync driven high");
    a_okay: assert property (p_okay) else $error("bad response");
    a_wp: assert property (p_wp) else $error("write granted");
    a_wpass: assert property (p_wpass) else $error("grant wrong");
    a_auto: assert property (p_auto) else $error("not ready");
endmodule // obsl_properties

// >>> tb/obsl_fixture.sv
`timescale 1ns/100ps
module obsl_fixture (
    input wire [2:0] jmp,
    input wire [2:0] oe,
    input wire [2:0] pull,
    output wire [2:0] strap_n,
    output wire [2:0] lvl
);
    // Fitted jumper ties its strap to ground
    assign strap_n = ~jmp;
    // Pull-up lines; whoever pulls low wins
    assign lvl = ~(oe | pull);
endmodule // obsl_fixture

// >>> tb/option_bay_signal_logic_tb_top.sv
`timescale 1ns/100ps
`include "obsl_consts.vh"
module option_bay_signal_logic_tb_top;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
    } obsl_row_t;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, jmp, pull, strap_n, lvl;
    logic [31:0] hwdata, hrdata, rdat;
    logic sync_out, sync_oe, activity_oe, fault_oe, prog1_oe, prog2_oe;
    logic user_write_req, user_write_grant, media_ready;
    int failures, n_compared, cnt, i;
    obsl_row_t rows [6] = '{
        '{`OBSL_REG_CTRL, 32'h7, 32'h7},
        '{`OBSL_REG_IRQ_MASK, 32'h1f, 32'h1f},
        '{`OBSL_REG_SYNC_CFG, 32'h28, 32'h28},
        '{`OBSL_REG_PROG_CFG, 32'h3, 32'h3},
        '{`OBSL_REG_TEST_OUT, 32'h1f, 32'h1f},
        '{8'h40, 32'hffffffff, 32'h0}};
    assign hready = hreadyout;
    obsl_option_bay dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .test_mode_n(strap_n[0]), .auto_start_n(strap_n[1]),
        .write_inhibit_n(strap_n[2]), .sync_in(lvl[0]), .sync_out(sync_out),
        .sync_oe(sync_oe), .activity_oe(activity_oe), .fault_oe(fault_oe),
        .prog1_in(lvl[1]), .prog1_oe(prog1_oe), .prog2_in(lvl[2]),
        .prog2_oe(prog2_oe), .user_write_req(user_write_req),
        .user_write_grant(user_write_grant), .media_ready(media_ready));
    obsl_fixture fix_u (.jmp(jmp), .oe({prog2_oe, prog1_oe, sync_oe}),
        .pull(pull), .strap_n(strap_n), .lvl(lvl));
    // ----
    // Shared tasks
    // ----
    task tally_and_finish;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Bounded wait for the slave's ready
    task ack;
        cnt = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            cnt++;
            if (cnt > 50) begin
                failures++;
                tally_and_finish;
            end
            @(posedge hclk);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        ack;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        ack;
        rdat = hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task rst;
        hresetn <= 1'b0;
        wt(10);
        chk(sync_out, 1'b1);
        hresetn <= 1'b1;
        wt(1);
    endtask
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // ----
    // Main sequence
    // ----
    initial begin
        {hsel, hwrite, user_write_req, haddr, htrans, hwdata} <= '0;
        hsize <= 3'h2;
        jmp <= 3'b010;
        pull <= 3'h0;
        rst;
        foreach (rows[k]) begin
            bus(1'b1, rows[k].a, rows[k].d);
            rd(rows[k].a, rows[k].q);
        end
        rd(`OBSL_REG_STRAP, 32'h9);
        jmp <= 3'b100;
        user_write_req <= 1'b1;
        wt(3);
        chk(user_write_grant, 1'b1);
        user_write_req <= 1'b0;
        rd(`OBSL_REG_STRAP, 32'h9);
        rst;
        rd(`OBSL_REG_STRAP, 32'h2);
        chk(media_ready, 1'b0);
        bus(1'b1, `OBSL_REG_CTRL, 32'h4);
        wt(2);
        chk(media_ready, 1'b1);
        bus(1'b1, `OBSL_REG_IRQ_MASK, 32'h8);
        user_write_req <= 1'b1;
        wt(3);
        chk(user_write_grant, 1'b0);
        user_write_req <= 1'b0;
        wt(2);
        chk(irq, 1'b1);
        rd(`OBSL_REG_IRQ_STAT, 32'h8);
        wt(2);
        chk(irq, 1'b0);
        bus(1'b1, `OBSL_REG_CTRL, 32'h6);
        wt(2);
        chk({activity_oe, fault_oe}, 2'b01);
        bus(1'b1, `OBSL_REG_CTRL, 32'h5);
        wt(2);
        chk({activity_oe, fault_oe}, 2'b10);
        bus(1'b1, `OBSL_REG_CTRL, 32'hc);
        for (i = 0; i < 10 && sync_oe !== 1'b1; i++) wt(1);
        for (i = 0; i < 100 && sync_oe === 1'b1; i++) wt(1);
        chk(i, `OBSL_SYNC_WIDTH_RST);
        pull <= 3'b001;
        wt(2);
        rd(`OBSL_REG_PIN_IN, 32'h1);
        pull <= 3'b000;
        rd(`OBSL_REG_IRQ_STAT, 32'h1);
        bus(1'b1, `OBSL_REG_PROG_CFG, 32'h5);
        pull <= 3'b100;
        wt(2);
        chk({prog2_oe, prog1_oe}, 2'b01);
        rd(`OBSL_REG_IRQ_STAT, 32'h4);
        pull <= 3'b000;
        jmp <= 3'b101;
        bus(1'b1, `OBSL_REG_CTRL, 32'h4);
        bus(1'b1, `OBSL_REG_TEST_OUT, 32'h2);
        wt(2);
        chk(activity_oe, 1'b1);
        jmp <= 3'b100;
        wt(3);
        chk(activity_oe, 1'b0);
        rd(`OBSL_REG_IRQ_STAT, 32'h10);
        tally_and_finish;
    end
endmodule // option_bay_signal_logic_tb_top
bind obsl_option_bay obsl_properties u_props (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .test_mode_n(test_mode_n),
    .auto_start_n(auto_start_n), .write_inhibit_n(write_inhibit_n),
    .sync_out(sync_out), .sync_oe(sync_oe), .activity_oe(activity_oe),
    .fault_oe(fault_oe), .user_write_req(user_write_req),
    .user_write_grant(user_write_grant), .media_ready(media_ready));
